// [design/mcp_dma_end.sv]
// Purpose: transmit and receive dma channel pair driving one copy
// Assumes: source elements arrive on src_*, destination leaves on dst_*
// Notes:   one size value loads both channel counters
`timescale 1ns/1ps
`include "mcp_regs.svh"

module mcp_dma_end (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    mcp_link_if.dma                     link,
    input  wire logic                   start,
    input  wire logic [`MCP_CNT_W-1:0]  buf_size,
    input  wire logic                   src_valid,
    input  wire logic [`MCP_DATA_W-1:0] src_data,
    output logic                        src_ready,
    output logic                        dst_valid,
    output logic [`MCP_DATA_W-1:0]      dst_data,
    input  wire logic                   dst_ready,
    output logic                        busy
);
    mcp_pkg::mcp_state_e     st_q;
    logic [`MCP_CNT_W-1:0]   tx_cnt_q;
    logic [`MCP_CNT_W-1:0]   rx_cnt_q;
    logic                    tx_wr_q;
    logic [`MCP_DATA_W-1:0]  tx_data_q;
    logic                    rx_rd_q;
    logic                    eot_q;
    logic                    dst_valid_q;
    logic [`MCP_DATA_W-1:0]  dst_data_q;
    logic                    f_valid;
    logic [`MCP_DATA_W-1:0]  f_data;
    logic                    tx_fire;
    logic                    rx_fire;

    mcp_fifo #(.W(`MCP_DATA_W), .D(`MCP_FIFO_DEPTH)) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (src_valid),
        .in_data   (src_data),
        .in_ready  (src_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (tx_fire)
    );

    // one access to the holding register in flight at a time
    assign tx_fire = (st_q == mcp_pkg::st_run) && (tx_cnt_q != '0) && f_valid
                     && !link.hold_valid && !tx_wr_q && !rx_rd_q;
    assign rx_fire = (st_q == mcp_pkg::st_run) && (rx_cnt_q != '0) && link.hold_valid
                     && !rx_rd_q && !tx_wr_q && (!dst_valid_q || dst_ready);

    assign link.tx_wr           = tx_wr_q;
    assign link.tx_data         = tx_data_q;
    assign link.rx_rd           = rx_rd_q;
    assign link.end_of_transfer = eot_q;
    assign link.buffer_full     = eot_q;
    assign dst_valid            = dst_valid_q;
    assign dst_data             = dst_data_q;
    assign busy                 = (st_q == mcp_pkg::st_run);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q     <= mcp_pkg::st_idle;
            tx_cnt_q <= '0;
            rx_cnt_q <= '0;
            eot_q    <= 1'b0;
        end
        else
        begin
            case (st_q)
                mcp_pkg::st_idle, mcp_pkg::st_done:
                begin
                    if (start)
                    begin
                        st_q     <= mcp_pkg::st_run;
                        tx_cnt_q <= buf_size;
                        rx_cnt_q <= buf_size;
                        eot_q    <= 1'b0;
                    end
                end
                mcp_pkg::st_run:
                begin
                    if (tx_fire)
                        tx_cnt_q <= tx_cnt_q - 1'b1;
                    if (rx_fire)
                        rx_cnt_q <= rx_cnt_q - 1'b1;
                    if (rx_cnt_q == '0 && !rx_rd_q)
                    begin
                        st_q  <= mcp_pkg::st_done;
                        eot_q <= 1'b1;
                    end
                end
                default:
                    st_q <= mcp_pkg::st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_wr_q     <= 1'b0;
            tx_data_q   <= '0;
            rx_rd_q     <= 1'b0;
            dst_valid_q <= 1'b0;
            dst_data_q  <= '0;
        end
        else
        begin
            tx_wr_q <= tx_fire;
            rx_rd_q <= rx_fire;
            if (tx_fire)
                tx_data_q <= f_data;
            if (rx_fire)
            begin
                dst_valid_q <= 1'b1;
                dst_data_q  <= link.holding_value;
            end
            else if (dst_ready)
                dst_valid_q <= 1'b0;
        end
    end
endmodule : mcp_dma_end

// [design/mcp_fifo.sv]
// Purpose: element buffer on the source side of the transmit channel
// Assumes: single clock, valid/ready on both sides
// Notes:   out_data is shown ahead of the pop
`timescale 1ns/1ps

module mcp_fifo #(
    parameter int W = 32,
    parameter int D = 16
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rp_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge hclk)
    begin
        if (push)
            mem[wp_q] <= in_data;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= (wp_q == AW'(D-1)) ? '0 : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == AW'(D-1)) ? '0 : rp_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule : mcp_fifo

// [design/mcp_helper.sv]
// Purpose: memory copy helper, holding register between two dma channels
// Assumes: AHB-Lite slave, word transfers only, one wait state
// Notes:   irq is a level, copy_done a one-cycle pulse
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
`include "mcp_regs.svh"

module mcp_helper (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic [31:0]                 hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    mcp_link_if.dev                     link,
    output logic                        irq,
    output logic                        copy_done
);
    logic                    pend_q;
    logic                    hreadyout_q;
    logic                    hresp_q;
    logic [`MCP_AW-1:0]      addr_q;
    logic                    write_q;
    logic [31:0]             hrdata_q;
    logic [31:0]             rd_mux;
    logic                    wr_en;
    logic                    rd_en;

    logic [`MCP_DATA_W-1:0]  thr_q;
    logic                    hold_valid_q;
    logic [1:0]              mode_q;
    logic [1:0]              mask_q;
    logic [1:0]              status_q;
    logic [1:0]              status_d;
    logic                    irq_q;
    logic                    done_q;

    ////////////////////////////////////////////////////////////////////////
    // element width applied to what the transmit channel writes
    function automatic logic [31:0] mcp_fit(input logic [1:0] sz,
                                            input logic [31:0] v);
        logic [31:0] r;
        r = v;
        case (sz)
            mcp_pkg::size_byte:     r = {24'h00_0000, v[7:0]};
            mcp_pkg::size_halfword: r = {16'h0000, v[15:0]};
            default:                r = v;
        endcase
        return r;
    endfunction : mcp_fit

    assign hrdata    = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign irq       = irq_q;
    assign copy_done = done_q;

    assign link.holding_value = thr_q;
    assign link.hold_valid    = hold_valid_q;

    assign wr_en    = pend_q && write_q;
    assign rd_en    = pend_q && !write_q;
    assign status_d = {link.buffer_full, link.end_of_transfer};

    ////////////////////////////////////////////////////////////////////////
    // bus phases: address taken, one wait cycle, then answer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pend_q      <= 1'b0;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            addr_q      <= '0;
            write_q     <= 1'b0;
        end
        else
        begin
            hresp_q <= 1'b0;
            if (pend_q)
            begin
                pend_q      <= 1'b0;
                hreadyout_q <= 1'b1;
            end
            else if (hsel && htrans[1] && hready)
            begin
                pend_q      <= 1'b1;
                hreadyout_q <= 1'b0;
                addr_q      <= haddr[`MCP_AW-1:0];
                write_q     <= hwrite;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; reserved offsets and the write-only IER and IDR offsets read zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (addr_q)
            `MCP_OFF_THR: rd_mux = thr_q;
            `MCP_OFF_MR:  rd_mux = {30'h0000_0000, mode_q};
            `MCP_OFF_IMR: rd_mux = {30'h0000_0000, mask_q};
            `MCP_OFF_ISR: rd_mux = {30'h0000_0000, status_q};
            default:      rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0000_0000;
        else if (rd_en)
            hrdata_q <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////
    // holding register: channel write wins over a software write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            thr_q <= `MCP_THR_RESET;
        else if (link.tx_wr)
            thr_q <= mcp_fit(mode_q, link.tx_data);
        else if (wr_en && addr_q == `MCP_OFF_THR)
            thr_q <= hwdata;
    end

    // element waiting for the receive channel; set wins over clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hold_valid_q <= 1'b0;
        else if (link.tx_wr)
            hold_valid_q <= 1'b1;
        else if (link.rx_rd)
            hold_valid_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mode_q <= `MCP_MR_RESET;
        else if (wr_en && addr_q == `MCP_OFF_MR)
            mode_q <= hwdata[1:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            mask_q <= `MCP_IMR_RESET;
        else if (wr_en && addr_q == `MCP_OFF_IER)
            mask_q <= mask_q | hwdata[`MCP_BIT_BUFF:`MCP_BIT_EOT];
        else if (wr_en && addr_q == `MCP_OFF_IDR)
            mask_q <= mask_q & ~hwdata[`MCP_BIT_BUFF:`MCP_BIT_EOT];
    end

    ////////////////////////////////////////////////////////////////////////
    // status follows the receive channel levels one cycle later
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_q <= `MCP_ISR_RESET;
        else
            status_q <= status_d;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            done_q <= 1'b0;
        else
            done_q <= |(status_d & ~status_q);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(status_q & mask_q);
    end
endmodule : mcp_helper

// [design/mcp_link_if.sv]
// Purpose: link between the copy helper and the dma channel pair
// Assumes: both ends on hclk
// Notes:   one modport per end
`timescale 1ns/1ps
`include "mcp_regs.svh"

interface mcp_link_if;
    logic                   tx_wr;
    logic [`MCP_DATA_W-1:0] tx_data;
    logic                   rx_rd;
    logic [`MCP_DATA_W-1:0] holding_value;
    logic                   hold_valid;
    logic                   end_of_transfer;
    logic                   buffer_full;

    modport dev
    (
        input  tx_wr,
        input  tx_data,
        input  rx_rd,
        input  end_of_transfer,
        input  buffer_full,
        output holding_value,
        output hold_valid
    );

    modport dma
    (
        output tx_wr,
        output tx_data,
        output rx_rd,
        output end_of_transfer,
        output buffer_full,
        input  holding_value,
        input  hold_valid
    );
endinterface : mcp_link_if

// [design/mcp_pkg.sv]
// Purpose: shared types of the copy helper
// Assumes: nothing
// Notes:   constants live in mcp_regs.svh
package mcp_pkg;

    typedef enum logic [1:0]
    {
        size_byte     = 2'h0,
        size_halfword = 2'h1,
        size_word     = 2'h2
    } mcp_size_e;

    typedef enum logic [1:0]
    {
        st_idle = 2'b00,
        st_run  = 2'b01,
        st_done = 2'b11
    } mcp_state_e;

endpackage : mcp_pkg

// [design/mcp_regs.svh]
// Purpose: register map, fields, reset values and sizes of the copy helper
// Assumes: 32-bit word registers, byte offsets
// Notes:   definitions only
`ifndef MCP_REGS_SVH
`define MCP_REGS_SVH

`define MCP_AW          12
`define MCP_OFF_THR     12'h000
`define MCP_OFF_MR      12'h004
`define MCP_OFF_IER     12'h008
`define MCP_OFF_IDR     12'h00C
`define MCP_OFF_IMR     12'h010
`define MCP_OFF_ISR     12'h014
`define MCP_THR_RESET   32'h0000_0000
`define MCP_MR_RESET    2'h2
`define MCP_IMR_RESET   2'h0
`define MCP_ISR_RESET   2'h0
`define MCP_BIT_EOT     0
`define MCP_BIT_BUFF    1
`define MCP_FIFO_DEPTH  16
`define MCP_DATA_W      32
`define MCP_CNT_W       16

`endif

// [tb/mcp_link_chk.sv]
// Purpose: link checks between helper and dma end
// Assumes: one clock, reset active low
// Notes:   sees only the link signals
`timescale 1ns/1ps
`include "mcp_regs.svh"

module mcp_link_chk (
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   tx_wr,
    input wire logic [`MCP_DATA_W-1:0] tx_data,
    input wire logic                   rx_rd,
    input wire logic [`MCP_DATA_W-1:0] holding_value,
    input wire logic                   hold_valid,
    input wire logic                   end_of_transfer,
    input wire logic                   buffer_full
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////
    sequence s_fill; ##1 hold_valid; endsequence
    sequence s_drain; ##1 !hold_valid; endsequence

    property p_hold_set; tx_wr |-> s_fill; endproperty
    property p_hold_clr; rx_rd |-> s_drain; endproperty
    property p_wr_empty; tx_wr |-> !hold_valid; endproperty
    property p_rd_full; rx_rd |-> hold_valid; endproperty
    property p_wr_gap; tx_wr |=> !rx_rd && !tx_wr; endproperty
    property p_hold_data;
        $rose(hold_valid) |-> (holding_value & ~$past(tx_data)) == 32'h0
            && ((holding_value ^ $past(tx_data)) & 32'h0000_00FF) == 32'h0;
    endproperty
    property p_flags_pair; end_of_transfer == buffer_full; endproperty
    property p_end_quiet; end_of_transfer |-> !tx_wr; endproperty

    ////////////////////////////////////////
    a_hold_set: assert property (p_hold_set)
        else $error("no element after write");
    a_hold_clr: assert property (p_hold_clr)
        else $error("element kept after read");
    a_wr_empty: assert property (p_wr_empty)
        else $error("write over waiting element");
    a_rd_full: assert property (p_rd_full)
        else $error("read with nothing waiting");
    a_wr_gap: assert property (p_wr_gap)
        else $error("write spacing broken");
    a_hold_data: assert property (p_hold_data)
        else $error("element value wrong");
    a_flags_pair: assert property (p_flags_pair)
        else $error("end and full differ");
    a_end_quiet: assert property (p_end_quiet)
        else $error("write after end");
endmodule : mcp_link_chk

// [tb/memory_copy_dma_helper_tb.sv]
// Purpose: self-checking bench of helper and dma end
// Assumes: 50 MHz hclk, single word bus transfers
// Notes:   model values kept in queues and masks
`timescale 1ns/1ps
`include "mcp_regs.svh"

module memory_copy_dma_helper_tb;
    logic                   hclk;
    logic                   hresetn;
    logic                   hsel;
    logic [31:0]            haddr;
    logic [1:0]             htrans;
    logic                   hwrite;
    logic [31:0]            hwdata;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic                   hresp;
    logic                   irq;
    logic                   copy_done;
    logic                   start;
    logic [`MCP_CNT_W-1:0]  buf_size;
    logic                   src_valid;
    logic [31:0]            src_data;
    logic                   src_ready;
    logic                   dst_valid;
    logic [31:0]            dst_data;
    logic                   dst_ready;
    logic                   busy;
    logic                   refused;
    logic [31:0]            rd;
    logic [31:0]            d;
    logic [31:0]            mask_m;
    logic [31:0]            exp_q[$];
    int                     n_mismatch;
    int                     compares;
    int                     seed;
    int                     n_done;
    int                     n_copy;
    localparam logic [11:0] OFFS [10] = '{12'h000, 12'h004, 12'h010, 12'h014, 12'h008,
                                          12'h00C, 12'h018, 12'h0FC, 12'h100, 12'h124};

    mcp_link_if link ();

    mcp_helper i_mcp_helper (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link(link), .irq(irq), .copy_done(copy_done));

    mcp_dma_end i_mcp_dma_end (.hclk(hclk), .hresetn(hresetn), .link(link),
        .start(start), .buf_size(buf_size), .src_valid(src_valid), .src_data(src_data),
        .src_ready(src_ready), .dst_valid(dst_valid), .dst_data(dst_data),
        .dst_ready(dst_ready), .busy(busy));

    mcp_link_chk i_mcp_link_chk (.hclk(hclk), .hresetn(hresetn), .tx_wr(link.tx_wr),
        .tx_data(link.tx_data), .rx_rd(link.rx_rd), .holding_value(link.holding_value),
        .hold_valid(link.hold_valid), .end_of_transfer(link.end_of_transfer),
        .buffer_full(link.buffer_full));

    ////////////////////////////////////////
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(posedge hclk)
        if (copy_done === 1'b1)
            n_done <= n_done + 1;

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task summarize;
        if (n_mismatch == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    // one single transfer, address then data phase
    task xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : xfer

    task copy(input logic [1:0] sz, input int n, input int hold);
        logic [31:0] m;
        int          got;
        int          c;
        m = (sz == 2'h0) ? 32'hFF : (sz == 2'h1) ? 32'hFFFF : 32'hFFFF_FFFF;
        d = $random(seed);
        xfer(`MCP_OFF_IER, 1'b1, d);
        mask_m = mask_m | (d & 32'h3);
        xfer(`MCP_OFF_MR, 1'b1, {30'h0, sz});
        @(posedge hclk);
        start    <= 1'b1;
        buf_size <= `MCP_CNT_W'(n);
        @(posedge hclk);
        start <= 1'b0;
        xfer(`MCP_OFF_ISR, 1'b0, 32'h0);
        chk(rd, 32'h0);
        got = 0;
        c = 0;
        refused = 1'b0;
        fork
            begin
                for (int i = 0; i < n; i++)
                begin
                    d = $random(seed);
                    exp_q.push_back(d & m);
                    src_valid <= 1'b1;
                    src_data  <= d;
                    do @(posedge hclk); while (src_ready !== 1'b1);
                end
                src_valid <= 1'b0;
            end
            begin
                while (got < n)
                begin
                    @(posedge hclk);
                    if (src_ready === 1'b0)
                        refused = 1'b1;
                    if (dst_valid === 1'b1 && dst_ready === 1'b1)
                    begin
                        chk(dst_data, exp_q.pop_front());
                        got++;
                    end
                    dst_ready <= (c >= hold) ? 1'($random(seed)) : 1'b0;
                    c++;
                end
            end
        join
        if (hold > 0)
            chk({31'h0, refused}, 32'h1);
        for (int i = 0; i < 40 && busy !== 1'b0; i++)
            @(posedge hclk);
        chk({31'h0, busy}, 32'h0);
        repeat (3) @(posedge hclk);
        n_copy++;
        xfer(`MCP_OFF_ISR, 1'b0, 32'h0);
        chk(rd, 32'h3);
        chk({31'h0, irq}, {31'h0, |mask_m[1:0]});
        chk(32'(n_done), 32'(n_copy));
    endtask : copy

    ////////////////////////////////////////
    initial
    begin
        seed = 9954;
        {hresetn, hsel, haddr, htrans, hwrite, hwdata} <= '0;
        {start, buf_size, src_valid, src_data, dst_ready} <= '0;
        {n_mismatch, compares, n_copy} = '0;
        n_done <= 0;
        mask_m = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            xfer(OFFS[i], 1'b0, 32'h0);
            chk(rd, (i == 1) ? 32'h2 : 32'h0);
        end
        for (int i = 6; i < 10; i++)
        begin
            xfer(OFFS[i], 1'b1, $random(seed));
            xfer(OFFS[i], 1'b0, 32'h0);
            chk(rd, 32'h0);
        end
        repeat (3)
        begin
            d = $random(seed);
            xfer(`MCP_OFF_THR, 1'b1, d);
            xfer(`MCP_OFF_THR, 1'b0, 32'h0);
            chk(rd, d);
        end
        for (int v = 0; v < 4; v++)
        begin
            d = $random(seed);
            xfer(`MCP_OFF_MR, 1'b1, {d[31:2], 2'(v)});
            xfer(`MCP_OFF_MR, 1'b0, 32'h0);
            chk(rd, 32'(v));
        end
        copy(2'h0, 5, 0);
        copy(2'h1, 7, 0);
        copy(2'h3, 3, 0);
        copy(2'h2, 20, 60);
        repeat (10)
        begin
            d = $random(seed);
            xfer(d[2] ? `MCP_OFF_IDR : `MCP_OFF_IER, 1'b1, d);
            mask_m = d[2] ? (mask_m & ~(d & 32'h3)) : (mask_m | (d & 32'h3));
            xfer(`MCP_OFF_IMR, 1'b0, 32'h0);
            chk(rd, mask_m);
            chk({31'h0, irq}, {31'h0, |mask_m[1:0]});
        end
        summarize();
    end

    initial
    begin
        #400000;
        n_mismatch++;
        summarize();
    end
endmodule : memory_copy_dma_helper_tb
